// >>> logic/lvdi_map.vh
// Register map, field positions and timing constants of the low voltage detector
//
// Overview of operation
// - Supply low after delay sets the low voltage interrupt request flag.
// - Vector call needs global enable, local enable, free stack, pending flag.
// - Servicing clears the request flag and the global enable.
// - Any rising request flag wakes SLEEP or IDLE, enable bits ignored.
// - A set flag stays until serviced or cleared by software.
// - Vector call pushes only the program counter.
// - Return with reenable sets global enable; plain return leaves it cleared.
// - Read-only bit 5 reads 1 while the detector is on and supply is below threshold.
// - Bit 4 switches the detector on when 1, off when 0.
// - Bandgap on when its bit, detector enable or reset supervisor is set.
// - Three-bit threshold field picks 2.0V to 4.0V, sent to comparator.
// - In SLEEP the detector is forced off despite its enable bit.
// - Request flag sets a fixed delay after status rising, or at once on a software write of bit 2.
// - Setting the low voltage flag wakes the device from IDLE.
// - Status bit follows the comparator with no hysteresis.
// - With the stack full no interrupt is acknowledged.
`ifndef LVDI_MAP_VH
`define LVDI_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define LVDI_OFS_CTRL     4'h0
`define LVDI_OFS_IRQ      4'h1
`define LVDI_OFS_STAT     4'h2

// ****************************************
// Control register fields
// ****************************************
`define LVDI_CTRL_RESET   8'h00
`define LVDI_BIT_LOW      5
`define LVDI_BIT_DET_EN   4
`define LVDI_BIT_BG_EN    3
`define LVDI_THR_MSB      2
`define LVDI_THR_LSB      0

// ****************************************
// Interrupt and status register fields
// ****************************************
`define LVDI_BIT_GIE      0
`define LVDI_BIT_LVE      1
`define LVDI_BIT_LVF      2
`define LVDI_BIT_SETTLED  0
`define LVDI_BIT_DET_ON   1
`define LVDI_BIT_STK_FULL 2

// ****************************************
// Timing
// ****************************************
`define LVDI_CLK_NS       100
`define LVDI_DELAY_NS     1000
`define LVDI_SETTLE_NS    2000
`define LVDI_DELAY_CYC    ((`LVDI_DELAY_NS + `LVDI_CLK_NS - 1) / `LVDI_CLK_NS)
`define LVDI_SETTLE_CYC   ((`LVDI_SETTLE_NS + `LVDI_CLK_NS - 1) / `LVDI_CLK_NS)

`endif

// >>> logic/lvdi_sync.v
// Two flip-flop synchroniser for the analog comparator output
`timescale 1ns/10ps
module lvdi_sync (
	// Clock and reset
	input  wire clock,
	input  wire rst,
	// Asynchronous level in, synchronous level out
	input  wire async_in,
	output reg  sync_out
);
	reg stage1;

	always @(posedge clock) begin
		if (rst) begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // lvdi_sync

// >>> logic/lvdi_timer.v
// Restartable cycle counter: pulses once after COUNT cycles of run held high
`timescale 1ns/10ps
module lvdi_timer #(
	parameter integer COUNT = 10,
	parameter integer W     = 16
) (
	// Clock and reset
	input  wire clock,
	input  wire rst,
	// Control and result
	input  wire run,
	output reg  fire,
	output reg  reached
);
	reg [W-1:0] cnt;

	always @(posedge clock) begin
		if (rst || !run) begin
			cnt     <= {W{1'b0}};
			reached <= 1'b0;
			fire    <= 1'b0;
		end else if (!reached) begin
			cnt <= cnt + 1'b1;
			if (cnt == COUNT[W-1:0] - 1'b1) begin
				reached <= 1'b1;
				fire    <= 1'b1;
			end else begin
				fire <= 1'b0;
			end
		end else begin
			fire <= 1'b0;
		end
	end
endmodule // lvdi_timer

// >>> logic/lvdi_top.v
// Low voltage detector control with its interrupt request, vectoring and wake-up
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "lvdi_map.vh"
module lvdi_top #(
	parameter integer PC_W        = 12,
	parameter integer NUM_OTHER   = 4,
	parameter integer DELAY_CYC   = `LVDI_DELAY_CYC,
	parameter integer SETTLE_CYC  = `LVDI_SETTLE_CYC,
	parameter integer TMR_W       = 16
) (
	// Clock and reset
	input  wire                 clock,
	input  wire                 rst,
	// Register port
	input  wire [3:0]           reg_addr,
	input  wire [7:0]           reg_wdata,
	input  wire                 reg_wr,
	input  wire                 reg_rd,
	output reg  [7:0]           reg_rdata,
	// Analog comparator and supervisor
	input  wire                 cmp_low,
	input  wire                 lvr_enable,
	output reg                  detector_on,
	output reg                  bandgap_on,
	output reg  [2:0]           threshold_out,
	// Core side
	input  wire                 stack_full,
	input  wire [PC_W-1:0]      pc_in,
	input  wire                 return_with_irq_reenable,
	input  wire                 plain_return,
	input  wire                 sleep_mode,
	input  wire                 idle_mode,
	input  wire [NUM_OTHER-1:0] other_irq_flags,
	output reg                  vector_call,
	output reg                  pc_push,
	output reg  [PC_W-1:0]      pc_push_data,
	output reg                  wake,
	output reg                  global_irq_enable,
	output reg                  low_voltage_irq_flag
);

	// ****************************************
	// Register state
	// ****************************************
	reg                  detector_enable;
	reg                  bandgap_enable;
	reg [2:0]            threshold_select;
	reg                  low_voltage_irq_enable;
	reg                  supply_low_status;
	localparam [7:0]     CTRL_RST = `LVDI_CTRL_RESET;

	wire                 cmp_sync;
	wire                 delay_fire;
	wire                 settled;

	wire wr_ctrl;
	wire wr_irq;
	assign wr_ctrl = reg_wr && (reg_addr == `LVDI_OFS_CTRL);
	assign wr_irq  = reg_wr && (reg_addr == `LVDI_OFS_IRQ);

	// ****************************************
	// Comparator path
	// ****************************************
	lvdi_sync u_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in (cmp_low),
		.sync_out (cmp_sync)
	);

	// Status is only meaningful while the comparator is powered
	// status reflects low supply
	always @(posedge clock) begin
		if (rst)
			supply_low_status <= 1'b0;
		else
			supply_low_status <= detector_on & cmp_sync;
	end

	lvdi_timer #(
		.COUNT (DELAY_CYC),
		.W     (TMR_W)
	) u_delay (
		.clock   (clock),
		.rst     (rst),
		.run     (supply_low_status),
		.fire    (delay_fire),
		.reached ()
	);

	// Settling indication helps software; the status bit is not held off meanwhile
	lvdi_timer #(
		.COUNT (SETTLE_CYC),
		.W     (TMR_W)
	) u_settle (
		.clock   (clock),
		.rst     (rst),
		.run     (detector_on),
		.fire    (),
		.reached (settled)
	);

	// ****************************************
	// Control register
	// ****************************************
	always @(posedge clock) begin
		if (rst) begin
			detector_enable  <= CTRL_RST[`LVDI_BIT_DET_EN];
			bandgap_enable   <= CTRL_RST[`LVDI_BIT_BG_EN];
			threshold_select <= CTRL_RST[`LVDI_THR_MSB:`LVDI_THR_LSB];
		end else if (wr_ctrl) begin
			detector_enable  <= reg_wdata[`LVDI_BIT_DET_EN];
			bandgap_enable   <= reg_wdata[`LVDI_BIT_BG_EN];
			threshold_select <= reg_wdata[`LVDI_THR_MSB:`LVDI_THR_LSB];
		end
	end

	// ****************************************
	// Analog controls
	// ****************************************
	always @(posedge clock) begin
		if (rst) begin
			detector_on   <= 1'b0;
			bandgap_on    <= 1'b0;
			threshold_out <= 3'h0;
		end else begin
			detector_on   <= detector_enable & ~sleep_mode;
			bandgap_on    <= bandgap_enable | detector_enable | lvr_enable;
			threshold_out <= threshold_select;
		end
	end

	// ****************************************
	// Interrupt vectoring
	// ****************************************
	wire take_call;
	assign take_call = global_irq_enable & low_voltage_irq_enable & low_voltage_irq_flag
	                   & ~stack_full & ~vector_call;

	reg next_flag;
	reg next_gie;

	always @* begin
		next_flag = low_voltage_irq_flag;
		if (wr_irq)
			next_flag = reg_wdata[`LVDI_BIT_LVF];
		if (take_call)
			next_flag = 1'b0;
		if (delay_fire)
			next_flag = 1'b1;
	end

	always @* begin
		next_gie = global_irq_enable;
		if (wr_irq)
			next_gie = reg_wdata[`LVDI_BIT_GIE];
		if (return_with_irq_reenable)
			next_gie = 1'b1;
		if (take_call)
			next_gie = 1'b0;
	end

	always @(posedge clock) begin
		if (rst) begin
			low_voltage_irq_flag   <= 1'b0;
			global_irq_enable      <= 1'b0;
			low_voltage_irq_enable <= 1'b0;
		end else begin
			low_voltage_irq_flag <= next_flag;
			global_irq_enable    <= next_gie;
			if (wr_irq)
				low_voltage_irq_enable <= reg_wdata[`LVDI_BIT_LVE];
		end
	end

	// Plain return needs no action: global enable simply stays as it is
	// push program counter only
	always @(posedge clock) begin
		if (rst) begin
			vector_call  <= 1'b0;
			pc_push      <= 1'b0;
			pc_push_data <= {PC_W{1'b0}};
		end else begin
			vector_call <= take_call;
			pc_push     <= take_call;
			if (take_call)
				pc_push_data <= pc_in;
		end
	end

	// ****************************************
	// Wake-up
	// ****************************************
	wire [NUM_OTHER:0] flags_now;
	wire [NUM_OTHER:0] flag_rise;
	assign flags_now = {other_irq_flags, low_voltage_irq_flag};

	// A flag already high before standby never rises, so it cannot wake
	// any rising flag wakes
	genvar gi;
	generate
		for (gi = 0; gi <= NUM_OTHER; gi = gi + 1) begin : g_rise
			reg prev;
			always @(posedge clock) begin
				if (rst)
					prev <= 1'b0;
				else
					prev <= flags_now[gi];
			end
			assign flag_rise[gi] = flags_now[gi] & ~prev;
		end
	endgenerate

	// low voltage flag wakes from idle
	always @(posedge clock) begin
		if (rst)
			wake <= 1'b0;
		else
			wake <= (sleep_mode | idle_mode) & (|flag_rise);
	end

	// ****************************************
	// Read port
	// ****************************************
	always @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= 8'h00;
			case (reg_addr)
				`LVDI_OFS_CTRL: begin
					reg_rdata[`LVDI_BIT_LOW]    <= supply_low_status;
					reg_rdata[`LVDI_BIT_DET_EN] <= detector_enable;
					reg_rdata[`LVDI_BIT_BG_EN]  <= bandgap_enable;
					reg_rdata[`LVDI_THR_MSB:`LVDI_THR_LSB] <= threshold_select;
				end
				`LVDI_OFS_IRQ: begin
					reg_rdata[`LVDI_BIT_GIE] <= global_irq_enable;
					reg_rdata[`LVDI_BIT_LVE] <= low_voltage_irq_enable;
					reg_rdata[`LVDI_BIT_LVF] <= low_voltage_irq_flag;
				end
				`LVDI_OFS_STAT: begin
					reg_rdata[`LVDI_BIT_SETTLED]  <= settled;
					reg_rdata[`LVDI_BIT_DET_ON]   <= detector_on;
					reg_rdata[`LVDI_BIT_STK_FULL] <= stack_full;
				end
				default: begin
					reg_rdata <= 8'h00;
				end
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule // lvdi_top

// >>> tb/lvdi_cmp_model.sv
// Behavioural analog supply comparator seen by the detector
`timescale 1ns/10ps
module lvdi_cmp_model (
	// Clock and supply level in millivolts
	input  wire       clock,
	input  int        supply_mv,
	// Detector side
	input  wire [2:0] threshold_out,
	input  wire       detector_on,
	output logic      cmp_low
);
	int thr_mv [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
	initial cmp_low = 1'b0;
	// Powered down output is junk, so it toggles
	// threshold compare, no hysteresis
	always @(posedge clock) begin
		if (detector_on)
			cmp_low <= supply_mv < thr_mv[threshold_out];
		else
			cmp_low <= !cmp_low;
	end
endmodule // lvdi_cmp_model

// >>> tb/lvdi_top_assertions.sv
// Concurrent checks on the ports of the detector top
`timescale 1ns/10ps
module lvdi_chk #(
	parameter integer PC_W      = 12,
	parameter integer DELAY_CYC = 10
) (
	// Clock, reset, register port
	input wire            clock,
	input wire            rst,
	input wire [3:0]      reg_addr,
	input wire            reg_wr,
	input wire            reg_rd,
	input wire [7:0]      reg_rdata,
	// Analog and core side
	input wire            cmp_low,
	input wire            lvr_enable,
	input wire            detector_on,
	input wire            bandgap_on,
	input wire            stack_full,
	input wire [PC_W-1:0] pc_in,
	input wire            return_with_irq_reenable,
	input wire            plain_return,
	input wire            sleep_mode,
	input wire            idle_mode,
	input wire            vector_call,
	input wire            pc_push,
	input wire [PC_W-1:0] pc_push_data,
	input wire            wake,
	input wire            global_irq_enable,
	input wire            low_voltage_irq_flag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire irq_wr = reg_wr && reg_addr == 4'h1;
	sequence s_call;
		vector_call ##1 !vector_call;
	endsequence
	a_call_cause: assert property (vector_call |->
		$past(global_irq_enable && low_voltage_irq_flag && !stack_full))
		else $error("vector call without its conditions");
	a_svc_clear: assert property (s_call |-> !$past(global_irq_enable))
		else $error("global enable kept after service");
	a_push_pair: assert property (pc_push == vector_call &&
		(!pc_push || pc_push_data == $past(pc_in)))
		else $error("push not paired with call");
	a_return_with_irq_reenable_sets: assert property (return_with_irq_reenable && !irq_wr |=>
		global_irq_enable || vector_call) else $error("return did not reenable");
	a_ret_keeps: assert property (plain_return && !global_irq_enable && !irq_wr &&
		!return_with_irq_reenable |=> !global_irq_enable) else $error("plain return set enable");
	a_flag_holds: assert property (low_voltage_irq_flag && !irq_wr |=>
		low_voltage_irq_flag || vector_call) else $error("flag lost");
	a_flag_delay: assert property ($rose(low_voltage_irq_flag) && !$past(irq_wr) |->
		$past(cmp_low, DELAY_CYC + 2)) else $error("flag set too early");
	a_wake_rise: assert property ($rose(low_voltage_irq_flag) &&
		(sleep_mode || idle_mode) |=> wake) else $error("no wake on flag rise");
	a_det_sleep: assert property (detector_on |-> !$past(sleep_mode) && bandgap_on)
		else $error("detector on in sleep");
	a_bg_lvr: assert property (!$past(rst) && $past(lvr_enable) |-> bandgap_on)
		else $error("bandgap off with supervisor on");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	c_call: cover property (s_call);
endmodule // lvdi_chk
bind lvdi_top lvdi_chk #(.PC_W(PC_W), .DELAY_CYC(DELAY_CYC)) lvdi_chk_inst (.*);

// >>> tb/low_voltage_detect_irq_tb_top.sv
// Self-checking bench for the low voltage detector top
`timescale 1ns/10ps
module low_voltage_detect_irq_tb_top;
	logic        clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0, other_irq_flags = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata;
	logic        cmp_low, detector_on, bandgap_on, vector_call, pc_push, wake;
	logic        global_irq_enable, low_voltage_irq_flag, lvr_enable = 1'b0;
	logic        stack_full = 1'b0, return_with_irq_reenable = 1'b0, plain_return = 1'b0;
	logic        sleep_mode = 1'b0, idle_mode = 1'b0;
	logic [2:0]  threshold_out;
	logic [11:0] pc_in = 12'h000, pc_push_data;
	int          supply_mv = 5000, n_errors = 0, samples_checked = 0;
	int          n_wake = 0, n_vec = 0, n_push = 0, m_ctrl = 0;
	lvdi_top #(.DELAY_CYC(5), .SETTLE_CYC(3)) lvdi_top_inst (.*);
	lvdi_cmp_model lvdi_cmp_model_inst (.*);
	always #50 clock = ~clock;
	always @(posedge clock) begin
		n_wake <= n_wake + (wake === 1'b1);
		n_vec <= n_vec + (vector_call === 1'b1);
		n_push <= n_push + (pc_push === 1'b1);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		if (a == 4'h0) m_ctrl = d & 8'h1F;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		void'($urandom(32'h0158));
		cyc(16);
		rst <= 1'b0;
		rd(4'h0, 8'h00);
		rd(4'hF, 8'h00);
		$display("Test reset done");
		for (int t = 0; t < 8; t++) begin
			@(posedge clock);
			lvr_enable <= 1'($urandom);
			wr(4'h0, 8'(t | (($urandom % 32) << 3)));
			rd(4'h0, 8'(m_ctrl));
			check(threshold_out, 32'(t));
			check(detector_on, 32'(m_ctrl >> 4 & 1));
			check(bandgap_on, 32'((m_ctrl >> 3 | m_ctrl >> 4 | lvr_enable) & 1));
		end
		$display("Test config done");
		wr(4'h0, 8'h13);
		supply_mv <= 2750;
		cyc(8);
		rd(4'h0, 8'h13);
		rd(4'h2, 8'h03);
		@(posedge clock);
		supply_mv <= 2650;
		cyc(8);
		rd(4'h1, 8'h00);
		rd(4'h0, 8'h33);
		rd(4'h1, 8'h04);
		$display("Test low supply done");
		@(posedge clock);
		pc_in <= 12'($urandom);
		stack_full <= 1'b1;
		wr(4'h1, 8'h07);
		cyc(6);
		#1 check(n_vec, 0);
		check(low_voltage_irq_flag, 1);
		rd(4'h2, 8'h07);
		@(posedge clock);
		stack_full <= 1'b0;
		cyc(4);
		#1 check(n_vec, 1);
		check(pc_push_data, pc_in);
		check(n_push, 1);
		check({global_irq_enable, low_voltage_irq_flag}, 0);
		// service ends in a return, no nested call
		@(posedge clock);
		plain_return <= 1'b1;
		@(posedge clock);
		plain_return <= 1'b0;
		return_with_irq_reenable <= 1'b1;
		#1 check(global_irq_enable, 0);
		@(posedge clock);
		return_with_irq_reenable <= 1'b0;
		rd(4'h1, 8'h03);
		$display("Test service done");
		wr(4'h1, 8'h00);
		supply_mv <= 5000;
		cyc(8);
		idle_mode <= 1'b1;
		supply_mv <= 2650;
		cyc(20);
		#1 check(n_wake, 1);
		@(posedge clock);
		idle_mode <= 1'b0;
		supply_mv <= 5000;
		cyc(8);
		wr(4'h1, 8'h04);
		idle_mode <= 1'b1;
		supply_mv <= 2650;
		cyc(20);
		#1 check(n_wake, 1);
		@(posedge clock);
		idle_mode <= 1'b0;
		sleep_mode <= 1'b1;
		cyc(2);
		rd(4'h0, 8'h13);
		rd(4'h2, 8'h00);
		@(posedge clock);
		other_irq_flags <= 4'h8;
		cyc(4);
		#1 check(n_wake, 2);
		check(detector_on, 0);
		$display("Test wake done");
		end_of_test;
	end
	// Whole run is under two hundred cycles
	initial begin
		#(100 * 5000);
		n_errors++;
		end_of_test;
	end
endmodule // low_voltage_detect_irq_tb_top
